// ---- dv/pmtv_host_model.sv ----
// pmtv_host_model: main-processor side, address register file for the decoder
// assumes: register n holds n in its top three bits, one clock shared with the decoder
`default_nettype none
module pmtv_host_model
(
	// clock
	input wire logic i_core_clk,
	// register request from the decoder
	input wire logic i_areg_req,
	input wire logic [2:0] i_areg_sel,
	// register value back
	output logic [31:0] o_areg_value
);
	timeunit 1ns;
	timeprecision 1ps;
	logic toggle = 1'b0;
	always @(posedge i_core_clk)
	begin
		toggle <= ~toggle;
	end
	// unrequested bus shows a pattern that flips every cycle
	assign o_areg_value = i_areg_req ? {i_areg_sel, 29'h0AB_CDEF} : {16{toggle, ~toggle}};
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// tb_top: drives instruction words at the falling edge and checks each directive
// assumes: decoder answers within a few cycles, host model supplies address registers
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic valid = 1'b0;
	logic sup = 1'b1;
	logic [15:0] word = 16'h0000;
	logic [31:0] ea = 32'h0000_0000;
	logic [31:0] vlev = 32'h0000_0000;
	logic [31:0] areg;
	logic [7:0] stat = 8'h00;
	logic [2:0] level_bit_count_field = 3'h3;
	logic [1:0] mc = 2'h1;
	logic dv, req, busy, fl, t;
	logic req_seen = 1'b0;
	logic [2:0] code, sel;
	logic [1:0] skip, nwd;
	int n_errors = 0;
	int total_checks = 0;
	always #10 clk = ~clk;
	pmtv_decoder i_dut(.i_core_clk(clk), .i_rst(rst), .i_word_valid(valid), .i_word(word),
		.i_supervisor(sup), .i_ea_addr(ea), .i_areg_value(areg), .i_mmu_status_reg(stat),
		.i_validate_level_reg(vlev), .i_level_bit_count_field(level_bit_count_field),
		.i_module_control_field(mc), .o_dir_valid(dv), .o_dir_code(code),
		.o_dir_skip_words(skip), .o_areg_req(req), .o_areg_sel(sel), .o_busy(busy));
	pmtv_host_model i_host(.i_core_clk(clk), .i_areg_req(req), .i_areg_sel(sel),
		.o_areg_value(areg));
	task automatic chk3(input logic [2:0] got, input logic [2:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one instruction: nw words offered back to back, then wait for the directive
	task automatic run(input logic [15:0] w0, input logic [15:0] w1, input int nw,
		input logic [2:0] ec, input logic [1:0] es);
		int k;
		@(negedge clk);
		valid = 1'b1;
		word = w0;
		if (nw > 1)
		begin
			@(negedge clk);
			word = w1;
			chk3({2'b00, busy}, 3'h1, "busy after first word");
		end
		@(negedge clk);
		valid = 1'b0;
		req_seen = req;
		for (k = 0; k < 8 && dv !== 1'b1; k++)
			@(negedge clk);
		chk3({2'b00, dv}, 3'h1, "directive pulse");
		chk3(code, ec, "directive code");
		chk3({1'b0, skip}, {1'b0, es}, "skip count");
		chk3({2'b00, busy}, 3'h0, "idle after directive");
	endtask
	function automatic logic [2:0] vexp(input logic [31:0] s, input logic [31:0] d);
		logic [31:0] ms, md;
		ms = (level_bit_count_field == 3'h0) ? 32'h0000_0000 : s >> (32 - level_bit_count_field);
		md = (level_bit_count_field == 3'h0) ? 32'h0000_0000 : d >> (32 - level_bit_count_field);
		if (mc == 2'h0 || ms > md)
			return pmtv_pkg::DIR_TRAP_LEVEL;
		return pmtv_pkg::DIR_CONTINUE;
	endfunction
	initial
	begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		for (int p = 0; p < 2; p++)
			for (int c = 0; c < 16; c++)
				for (int f = 2; f < 5; f++)
				begin
					stat = p ? 8'h5A : 8'hA5;
					fl = stat[c >> 1];
					t = c[0] ? ~fl : fl;
					nwd = (f == 2) ? 2'h1 : (f == 3) ? 2'h2 : 2'h0;
					run({pmtv_pkg::TRAP_W0_FIXED, f[2:0]}, {10'h000, c[5:0]}, 2,
						t ? pmtv_pkg::DIR_TRAP_COND : (nwd != 2'h0 ? pmtv_pkg::DIR_SKIP_OPERANDS
						: pmtv_pkg::DIR_CONTINUE), nwd);
				end
		run(16'hF07C, 16'h0010, 2, pmtv_pkg::DIR_TRAP_ILLEGAL, 2'h0);
		run(16'hF07C, 16'h0040, 2, pmtv_pkg::DIR_TRAP_ILLEGAL, 2'h0);
		sup = 1'b0;
		run(16'hF07C, 16'h0000, 2, pmtv_pkg::DIR_TRAP_PRIV, 2'h0);
		run(16'hF010, pmtv_pkg::VAL_EXT_LEVEL, 2, pmtv_pkg::DIR_TRAP_PRIV, 2'h0);
		sup = 1'b1;
		vlev = 32'h8000_0000;
		for (int m = 0; m < 8; m++)
			for (int r = 0; r < 8; r++)
			begin
				// logical address itself, top bits track the register field
				ea = {r[2:0], 29'h0000_0000};
				if (m == 2 || m == 5 || m == 6 || (m == 7 && r < 2))
					run({pmtv_pkg::VAL_W0_FIXED, m[2:0], r[2:0]}, pmtv_pkg::VAL_EXT_LEVEL, 2,
						vexp(vlev, ea), 2'h0);
				else
					run({pmtv_pkg::VAL_W0_FIXED, m[2:0], r[2:0]}, 16'h0000, 1,
						pmtv_pkg::DIR_TRAP_ILLEGAL, 2'h0);
			end
		vlev = 32'h0200_0000;
		ea = 32'h0000_0000;
		for (int n = 0; n < 8; n++)
		begin
			level_bit_count_field = n[2:0];
			run(16'hF010, pmtv_pkg::VAL_EXT_LEVEL, 2, vexp(vlev, ea), 2'h0);
			chk3({2'b00, req_seen}, 3'h0, "no register request");
		end
		mc = 2'h0;
		vlev = 32'h0000_0000;
		run(16'hF010, pmtv_pkg::VAL_EXT_LEVEL, 2, pmtv_pkg::DIR_TRAP_LEVEL, 2'h0);
		mc = 2'h1;
		level_bit_count_field = 3'h3;
		ea = 32'h8000_0000;
		for (int r = 0; r < 8; r++)
		begin
			run(16'hF028, {pmtv_pkg::VAL_EXT_AREG, r[2:0]}, 2,
				vexp({r[2:0], 29'h0AB_CDEF}, ea), 2'h0);
			chk3(sel, r[2:0], "register select");
			chk3({2'b00, req_seen}, 3'h1, "register request");
		end
		tally_and_finish();
	end
	initial
	begin
		#100000;
		n_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ---- rtl/pmtv_cond_eval.sv ----
// pmtv_cond_eval: evaluates a six-bit status condition
// assumes: combinational, condition fed from registered decoder state, flags straight from the status register input
`default_nettype none
module pmtv_cond_eval
(
	// condition and flags
	input wire logic [5:0] i_cond,
	input wire logic [7:0] i_flags,
	// result
	output logic o_legal,
	output logic o_true
);
	logic [7:0] sel;
	genvar g;
	generate
		for (g = 0; g < pmtv_pkg::FLAG_COUNT; g++)
		begin : g_sel
			assign sel[g] = (i_cond[3:1] == 3'(g)) & i_flags[g];
		end
	endgenerate
	assign o_legal = (i_cond <= pmtv_pkg::COND_LAST);
	// even tests set, odd tests clear
	assign o_true = o_legal & ((|sel) ^ i_cond[0]);
endmodule
`default_nettype wire

// ---- rtl/pmtv_decoder.sv ----
// pmtv_decoder: decodes and evaluates the conditional trap and pointer validate ops
// assumes: the main processor presents words one at a time with a valid strobe,
// computes effective addresses, supplies register values and carries out directives
//
// Contract
// - a true condition directs a trap through the coprocessor trap vector, next pc stacked.
// - a false condition makes the trap a no-op and execution continues.
// - even condition codes 0 to 14 test bus error, limit, super, access, wprot, invalid, gate, global set.
// - odd condition codes test the same flags for clear, from 1 to 15.
// - the form selector 010 gives one operand word, 011 two, and 100 none.
// - operand words after the condition word are skipped and never looked at.
// - the processor passes the condition field and the unit answers with directives.
// - validate compares the top level-count bits of source and destination address.
// - a greater source level raises an access-level exception, otherwise continue.
// - a zero module control field makes validate always raise the exception.
// - validate form one takes its reference from the internal validate level register.
// - validate form two takes its reference from the processor address register named in it.
// - only modes 010, 101, 110 and 111 with register 000 or 001 are accepted.
// - validate never alters the status register.
`default_nettype none
module pmtv_decoder
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// instruction words from the main processor
	input wire logic i_word_valid,
	input wire logic [15:0] i_word,
	input wire logic i_supervisor,
	// validate operands
	input wire logic [31:0] i_ea_addr,
	input wire logic [31:0] i_areg_value,
	// unit state
	input wire logic [7:0] i_mmu_status_reg,
	input wire logic [31:0] i_validate_level_reg,
	input wire logic [2:0] i_level_bit_count_field,
	input wire logic [1:0] i_module_control_field,
	// directive to the main processor
	output logic o_dir_valid,
	output logic [2:0] o_dir_code,
	output logic [1:0] o_dir_skip_words,
	output logic o_areg_req,
	output logic [2:0] o_areg_sel,
	output logic o_busy
);
	typedef enum logic [1:0] {S_IDLE, S_TRAP_COND, S_VAL_EXT, S_VAL_CMP} pmtv_state_type;
	pmtv_state_type state_ff, nxt_state;
	logic [2:0] form_ff, nxt_form;
	logic [5:0] ea_ff, nxt_ea;
	logic [5:0] cond_ff, nxt_cond;
	logic use_areg_ff, nxt_use_areg;
	logic dir_valid_ff, nxt_dir_valid;
	pmtv_pkg::pmtv_dir_type dir_ff, nxt_dir;
	logic [1:0] skip_ff, nxt_skip;
	logic [2:0] areg_ff, nxt_areg;
	logic cond_legal, cond_true;
	logic ea_ok, form_ok, src_greater;
	logic [31:0] src_level, mask;

	pmtv_cond_eval u_eval
	(
		.i_cond(cond_ff),
		.i_flags(i_mmu_status_reg),
		.o_legal(cond_legal),
		.o_true(cond_true)
	);

	// control alterable modes only
	always_comb
	begin
		unique case (i_word[5:3])
			pmtv_pkg::EA_MODE_IND, pmtv_pkg::EA_MODE_DISP, pmtv_pkg::EA_MODE_IDX:
				ea_ok = 1'b1;
			pmtv_pkg::EA_MODE_ABS:
				ea_ok = (i_word[2:0] == pmtv_pkg::EA_ABS_SHORT)
					| (i_word[2:0] == pmtv_pkg::EA_ABS_LONG);
			default:
				ea_ok = 1'b0;
		endcase
	end

	assign form_ok = (i_word[2:0] == pmtv_pkg::FORM_ONE_WORD)
		| (i_word[2:0] == pmtv_pkg::FORM_TWO_WORDS)
		| (i_word[2:0] == pmtv_pkg::FORM_NO_WORDS);

	// top level-count bits of source against the supplied address
	always_comb
	begin
		mask = ~(32'hFFFF_FFFF >> i_level_bit_count_field);
		src_level = use_areg_ff ? i_areg_value : i_validate_level_reg;
	end
	// address taken as given: the processor resolves indirection first
	assign src_greater = (src_level & mask) > (i_ea_addr & mask);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_form = form_ff;
		nxt_ea = ea_ff;
		nxt_cond = cond_ff;
		nxt_use_areg = use_areg_ff;
		nxt_dir_valid = 1'b0;
		nxt_dir = dir_ff;
		nxt_skip = skip_ff;
		nxt_areg = areg_ff;
		unique case (state_ff)
			S_IDLE:
			begin
				if (i_word_valid)
				begin
					if (i_word[15:3] == pmtv_pkg::TRAP_W0_FIXED && form_ok)
					begin
						nxt_form = i_word[2:0];
						nxt_state = S_TRAP_COND;
					end
					else if (i_word[15:6] == pmtv_pkg::VAL_W0_FIXED && ea_ok)
					begin
						nxt_ea = i_word[5:0];
						nxt_state = S_VAL_EXT;
					end
					else
					begin
						nxt_dir_valid = 1'b1;
						nxt_dir = pmtv_pkg::DIR_TRAP_ILLEGAL;
						nxt_skip = pmtv_pkg::RESET_SKIP;
					end
				end
			end
			S_TRAP_COND:
			begin
				if (i_word_valid)
				begin
					nxt_cond = i_word[5:0];
					nxt_state = S_IDLE;
					nxt_dir_valid = 1'b1;
					// operand words counted only, never read
					unique case (form_ff)
						pmtv_pkg::FORM_ONE_WORD: nxt_skip = 2'h1;
						pmtv_pkg::FORM_TWO_WORDS: nxt_skip = 2'h2;
						default: nxt_skip = 2'h0;
					endcase
					if (!i_supervisor)
						nxt_dir = pmtv_pkg::DIR_TRAP_PRIV;
					else if (i_word[15:6] != 10'h000)
						nxt_dir = pmtv_pkg::DIR_TRAP_ILLEGAL;
					else
					begin
						nxt_dir_valid = 1'b0;
						nxt_state = S_VAL_CMP;
						nxt_use_areg = 1'b0;
						nxt_ea = 6'h3F;
					end
				end
			end
			S_VAL_EXT:
			begin
				if (i_word_valid)
				begin
					nxt_state = S_IDLE;
					nxt_dir_valid = 1'b1;
					nxt_skip = pmtv_pkg::RESET_SKIP;
					if (!i_supervisor)
						nxt_dir = pmtv_pkg::DIR_TRAP_PRIV;
					else if (i_word == pmtv_pkg::VAL_EXT_LEVEL)
					begin
						nxt_use_areg = 1'b0;
						nxt_dir_valid = 1'b0;
						nxt_state = S_VAL_CMP;
					end
					else if (i_word[15:3] == pmtv_pkg::VAL_EXT_AREG)
					begin
						nxt_use_areg = 1'b1;
						nxt_areg = i_word[2:0];
						nxt_dir_valid = 1'b0;
						nxt_state = S_VAL_CMP;
					end
					else
						nxt_dir = pmtv_pkg::DIR_TRAP_ILLEGAL;
				end
			end
			S_VAL_CMP:
			begin
				nxt_state = S_IDLE;
				nxt_dir_valid = 1'b1;
				if (ea_ff == 6'h3F)
				begin
					// condition evaluation for the trap
					if (!cond_legal)
						nxt_dir = pmtv_pkg::DIR_TRAP_ILLEGAL;
					else if (cond_true)
						nxt_dir = pmtv_pkg::DIR_TRAP_COND;
					else if (skip_ff != 2'h0)
						nxt_dir = pmtv_pkg::DIR_SKIP_OPERANDS;
					else
						nxt_dir = pmtv_pkg::DIR_CONTINUE;
				end
				else
				begin
					nxt_skip = pmtv_pkg::RESET_SKIP;
					if (i_module_control_field == 2'h0 || src_greater)
						nxt_dir = pmtv_pkg::DIR_TRAP_LEVEL;
					else
						nxt_dir = pmtv_pkg::DIR_CONTINUE;
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_ff <= S_IDLE;
			form_ff <= 3'h0;
			ea_ff <= 6'h00;
			cond_ff <= 6'h00;
			use_areg_ff <= 1'b0;
			dir_valid_ff <= 1'b0;
			dir_ff <= pmtv_pkg::DIR_NONE;
			skip_ff <= pmtv_pkg::RESET_SKIP;
			areg_ff <= 3'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			form_ff <= nxt_form;
			ea_ff <= nxt_ea;
			cond_ff <= nxt_cond;
			use_areg_ff <= nxt_use_areg;
			dir_valid_ff <= nxt_dir_valid;
			dir_ff <= nxt_dir;
			skip_ff <= nxt_skip;
			areg_ff <= nxt_areg;
		end
	end

	// status register is an input only, never written
	assign o_dir_valid = dir_valid_ff;
	assign o_dir_code = dir_ff;
	assign o_dir_skip_words = skip_ff;
	assign o_areg_req = (state_ff == S_VAL_CMP) && use_areg_ff;
	assign o_areg_sel = areg_ff;
	assign o_busy = (state_ff != S_IDLE);

	a_true_traps: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_ff == S_VAL_CMP && ea_ff == 6'h3F && cond_legal && cond_true)
		|=> (o_dir_valid && o_dir_code == pmtv_pkg::DIR_TRAP_COND))
		else $error("true condition did not trap");
	a_false_continues: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_ff == S_VAL_CMP && ea_ff == 6'h3F && cond_legal && !cond_true)
		|=> (o_dir_valid && o_dir_code != pmtv_pkg::DIR_TRAP_COND))
		else $error("false condition trapped");
	a_skip_two: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_ff == S_TRAP_COND && form_ff == pmtv_pkg::FORM_TWO_WORDS && i_word_valid)
		|=> (o_dir_skip_words == 2'h2))
		else $error("two-word form skip count wrong");
	a_mc_zero_trap: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_ff == S_VAL_CMP && ea_ff != 6'h3F && i_module_control_field == 2'h0)
		|=> (o_dir_code == pmtv_pkg::DIR_TRAP_LEVEL))
		else $error("zero module control did not trap");
	// operands judged in the compare cycle, a shift by 32 compares nothing
	a_level_compare: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_ff == S_VAL_CMP && ea_ff != 6'h3F && i_module_control_field != 2'h0
		&& ((use_areg_ff ? i_areg_value : i_validate_level_reg)
		>> (32 - i_level_bit_count_field))
		> (i_ea_addr >> (32 - i_level_bit_count_field)))
		|=> (o_dir_code == pmtv_pkg::DIR_TRAP_LEVEL))
		else $error("less privileged source did not trap");
	a_level_pass: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_ff == S_VAL_CMP && ea_ff != 6'h3F && i_module_control_field != 2'h0
		&& ((use_areg_ff ? i_areg_value : i_validate_level_reg)
		>> (32 - i_level_bit_count_field))
		<= (i_ea_addr >> (32 - i_level_bit_count_field)))
		|=> (o_dir_code == pmtv_pkg::DIR_CONTINUE))
		else $error("privileged source trapped");
	a_priv_check: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_word_valid && !i_supervisor && (state_ff == S_TRAP_COND || state_ff == S_VAL_EXT))
		|=> (o_dir_valid && o_dir_code == pmtv_pkg::DIR_TRAP_PRIV))
		else $error("user-state op not privilege trapped");
	a_bad_ea: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_ff == S_IDLE && i_word_valid && i_word[15:6] == pmtv_pkg::VAL_W0_FIXED
		&& i_word[5:3] == 3'h0) |=> (state_ff == S_IDLE && o_dir_valid))
		else $error("data register mode accepted");
	a_areg_select: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_ff == S_VAL_EXT && i_word_valid && i_supervisor
		&& i_word[15:3] == pmtv_pkg::VAL_EXT_AREG)
		|=> (o_areg_req && o_areg_sel == $past(i_word[2:0])))
		else $error("address register not selected");
endmodule
`default_nettype wire

// ---- rtl/pmtv_pkg.sv ----
// pmtv_pkg: constants for the trap-on-condition and pointer-validate decoder
// assumes: used by the decoder and its evaluator, nothing imported
`default_nettype none
package pmtv_pkg;
	// first word of the conditional trap: bits 15..3 fixed, low three the form selector
	localparam logic [12:0] TRAP_W0_FIXED = 13'h1E0F;
	localparam logic [2:0] FORM_ONE_WORD = 3'h1 + 3'h1;
	localparam logic [2:0] FORM_TWO_WORDS = 3'h3;
	localparam logic [2:0] FORM_NO_WORDS = 3'h4;
	// first word of the validate op: bits 15..6 fixed, low six the effective address
	localparam logic [9:0] VAL_W0_FIXED = 10'h3C0;
	// extension words: form one and form two (low three bits select the register)
	localparam logic [15:0] VAL_EXT_LEVEL = 16'h2800;
	localparam logic [12:0] VAL_EXT_AREG = 13'h0580;
	// effective address modes accepted
	localparam logic [2:0] EA_MODE_IND = 3'h2;
	localparam logic [2:0] EA_MODE_DISP = 3'h5;
	localparam logic [2:0] EA_MODE_IDX = 3'h6;
	localparam logic [2:0] EA_MODE_ABS = 3'h7;
	localparam logic [2:0] EA_ABS_SHORT = 3'h0;
	localparam logic [2:0] EA_ABS_LONG = 3'h1;
	// condition field
	localparam int COND_W = 6;
	localparam logic [5:0] COND_LAST = 6'h0F;
	localparam int FLAG_COUNT = 8;
	// status flag positions, in condition order
	localparam int FLAG_BUS_ERR = 0;
	localparam int FLAG_LIMIT = 1;
	localparam int FLAG_SUPER = 2;
	localparam int FLAG_ACCESS = 3;
	localparam int FLAG_WPROT = 4;
	localparam int FLAG_INVALID = 5;
	localparam int FLAG_GATE = 6;
	localparam int FLAG_GLOBAL = 7;
	// directive codes returned to the main processor
	typedef enum logic [2:0] {
		DIR_NONE,
		DIR_CONTINUE,
		DIR_SKIP_OPERANDS,
		DIR_TRAP_COND,
		DIR_TRAP_LEVEL,
		DIR_TRAP_PRIV,
		DIR_TRAP_ILLEGAL
	} pmtv_dir_type;
	localparam logic [1:0] RESET_SKIP = 2'h0;
endpackage
`default_nettype wire
